// ---- dcf_pkg.sv ----
// Shared constants for the single-clock flagged FIFO channel
package dcf_pkg;
    localparam int          DATA_W      = 9;
    localparam int          ADDR_W      = 8;
    localparam int          PTR_W       = 9;
    localparam int          OFF_W       = 12;
    localparam logic [12:0] DEPTH       = 13'h0100;
    localparam logic [11:0] OFF_DEFAULT = 12'h007;
    localparam int          BUF_DEPTH   = 2;

    // Wishbone register byte addresses
    localparam logic [7:0]  ADR_STATUS  = 8'h00;
    localparam logic [7:0]  ADR_EOFF    = 8'h04;
    localparam logic [7:0]  ADR_FOFF    = 8'h08;

    // Status register field positions
    localparam int          ST_EMPTY_N  = 0;
    localparam int          ST_AEMPTY_N = 1;
    localparam int          ST_AFULL_N  = 2;
    localparam int          ST_FULL_N   = 3;
    localparam int          ST_OFFMODE  = 4;
    localparam int          ST_COUNT    = 8;

    // Offset register access sequence
    typedef enum logic [1:0] {
        DCF_SEQ_ELSB = 2'b00,
        DCF_SEQ_EMSB = 2'b01,
        DCF_SEQ_FLSB = 2'b10,
        DCF_SEQ_FMSB = 2'b11
    } dcf_seq_type;
endpackage : dcf_pkg

// ---- dcf_ptr_if.sv ----
// Pointer, offset and flag bundle between the channel core and the flag logic
interface dcf_ptr_if;
    logic                        wr_inc;
    logic                        rd_inc;
    logic [dcf_pkg::PTR_W-1:0]   wr_ptr;
    logic [dcf_pkg::PTR_W-1:0]   wr_sync;
    logic [dcf_pkg::OFF_W-1:0]   empty_off;
    logic [dcf_pkg::OFF_W-1:0]   full_off;
    logic [dcf_pkg::PTR_W-1:0]   count;
    logic                        empty_n;
    logic                        full_n;
    logic                        aempty_n;
    logic                        afull_n;

    modport core  (output wr_inc, rd_inc, empty_off, full_off,
                   input  wr_ptr, wr_sync, count, empty_n, full_n, aempty_n, afull_n);
    modport flags (input  wr_inc, rd_inc, empty_off, full_off,
                   output wr_ptr, wr_sync, count, empty_n, full_n, aempty_n, afull_n);
endinterface : dcf_ptr_if

// ---- dcf_buf.sv ----
// Two-entry valid/ready buffer in front of the read port
module dcf_buf (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        in_valid_i,
    output logic                             in_ready_o,
    input  wire logic [dcf_pkg::DATA_W-1:0]  in_data_i,
    output logic                             out_valid_o,
    input  wire logic                        out_ready_i,
    output logic [dcf_pkg::DATA_W-1:0]       out_data_o
);
    logic [dcf_pkg::DATA_W-1:0] slot_q [dcf_pkg::BUF_DEPTH];
    logic [1:0]                 cnt_q;
    logic                       push;
    logic                       pop;
    logic [1:0]                 idx;

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = slot_q[0];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign idx         = cnt_q - {1'b0, pop};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_i) begin
        if (pop) begin
            slot_q[0] <= slot_q[1];
        end
        if (push) begin
            slot_q[idx[0]] <= in_data_i;
        end
    end
endmodule : dcf_buf

// ---- dcf_flags.sv ----
// Pointers and the four flags, empty and almost-empty from a registered copy of the write pointer
module dcf_flags (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    dcf_ptr_if.flags   p
);
    logic [dcf_pkg::PTR_W-1:0] wr_q;
    logic [dcf_pkg::PTR_W-1:0] cons_q;
    logic [dcf_pkg::PTR_W-1:0] wr_sync_q;
    logic [dcf_pkg::PTR_W-1:0] wr_d;
    logic [dcf_pkg::PTR_W-1:0] cons_d;
    logic [dcf_pkg::PTR_W-1:0] wcount;
    logic [dcf_pkg::PTR_W-1:0] rcount;
    logic [12:0]               afull_level;
    logic                      empty_n_q;
    logic                      full_n_q;
    logic                      aempty_n_q;
    logic                      afull_n_q;
    logic [dcf_pkg::PTR_W-1:0] count_q;

    assign wr_d        = wr_q + {{(dcf_pkg::PTR_W-1){1'b0}}, p.wr_inc};
    assign cons_d      = cons_q + {{(dcf_pkg::PTR_W-1){1'b0}}, p.rd_inc};
    // Write side sees the read pointer one clock late
    assign wcount      = wr_d - cons_q;
    // Read side sees the write pointer two clocks late
    assign rcount      = wr_sync_q - cons_d;
    assign afull_level = dcf_pkg::DEPTH - {1'b0, p.full_off};

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q      <= '0;
            cons_q    <= '0;
            wr_sync_q <= '0;
        end else begin
            wr_q      <= wr_d;
            cons_q    <= cons_d;
            wr_sync_q <= wr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_n_q  <= 1'b1;
            afull_n_q <= 1'b1;
        end else begin
            full_n_q  <= ({4'h0, wcount} != dcf_pkg::DEPTH);
            afull_n_q <= ({4'h0, wcount} < afull_level);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            empty_n_q  <= 1'b0;
            aempty_n_q <= 1'b0;
            count_q    <= '0;
        end else begin
            empty_n_q  <= (rcount != '0);
            aempty_n_q <= ({3'h0, rcount} > p.empty_off);
            count_q    <= rcount;
        end
    end

    assign p.wr_ptr   = wr_q;
    assign p.wr_sync  = wr_sync_q;
    assign p.count    = count_q;
    assign p.empty_n  = empty_n_q;
    assign p.full_n   = full_n_q;
    assign p.aempty_n = aempty_n_q;
    assign p.afull_n  = afull_n_q;
endmodule : dcf_flags

// ---- dcf_top.sv ----
// One flagged FIFO channel with strap-selected offset mode and Wishbone registers
//
// What this block does
// - Empty flag may clear one read edge late
// - First word readable two clocks after its write
// - Almost-full change may slip one write edge
// - Almost-full low at capacity minus full offset
// - Almost-empty change may slip one read edge
// - Almost-empty low at empty offset or fewer
// - Load strap low at reset selects offset mode
// - Load strap high selects second enable, defaults
// - Offsets default to seven words
// - Empty flag low when pointers are equal
module dcf_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic [dcf_pkg::DATA_W-1:0]  wr_data_i,
    input  wire logic                        write_enable_n_i,
    input  wire logic                        write_enable_second_or_load_n_i,
    input  wire logic                        read_enable_n_i,
    input  wire logic                        read_enable_second_n_i,
    output logic [dcf_pkg::DATA_W-1:0]       rd_data_o,
    output logic                             empty_flag_n_o,
    output logic                             full_flag_n_o,
    output logic                             almost_empty_flag_n_o,
    output logic                             almost_full_flag_n_o,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o
);
    dcf_ptr_if p ();

    logic [dcf_pkg::DATA_W-1:0]  mem_q [1 << dcf_pkg::ADDR_W];
    logic [dcf_pkg::PTR_W-1:0]   fetch_q;
    logic                        offset_mode_q;
    dcf_pkg::dcf_seq_type        seq_q;
    logic [dcf_pkg::OFF_W-1:0]   eoff_q;
    logic [dcf_pkg::OFF_W-1:0]   foff_q;
    logic [dcf_pkg::DATA_W-1:0]  rd_data_q;
    logic [31:0]                 wb_dat_q;
    logic                        wb_ack_q;
    logic                        load_n;
    logic                        read_both;
    logic                        load_wr;
    logic                        load_rd;
    logic                        data_wr;
    logic                        data_rd;
    logic                        buf_in_valid;
    logic                        buf_in_ready;
    logic                        buf_out_valid;
    logic [dcf_pkg::DATA_W-1:0]  buf_out_data;
    logic                        wb_req;
    logic                        wb_wr;

    function automatic logic [dcf_pkg::DATA_W-1:0] off_byte(
        input dcf_pkg::dcf_seq_type     sel,
        input logic [dcf_pkg::OFF_W-1:0] eo,
        input logic [dcf_pkg::OFF_W-1:0] fo
    );
        case (sel)
            dcf_pkg::DCF_SEQ_ELSB: off_byte = {1'b0, eo[7:0]};
            dcf_pkg::DCF_SEQ_EMSB: off_byte = {5'h00, eo[11:8]};
            dcf_pkg::DCF_SEQ_FLSB: off_byte = {1'b0, fo[7:0]};
            dcf_pkg::DCF_SEQ_FMSB: off_byte = {5'h00, fo[11:8]};
            default:               off_byte = '0;
        endcase
    endfunction : off_byte

    ////////////////////////////////////////////////////////////////////////////
    // Pin decode
    assign load_n    = write_enable_second_or_load_n_i;
    assign read_both = ~read_enable_n_i & ~read_enable_second_n_i;
    assign load_wr   = offset_mode_q & ~load_n & ~write_enable_n_i;
    // Offset read only when not loading: load wins a simultaneous request
    assign load_rd   = offset_mode_q & ~load_n & read_both & ~load_wr;
    assign data_wr   = ~write_enable_n_i & (offset_mode_q ? load_n : ~load_n)
                       & p.full_n;
    assign data_rd   = read_both & ~(offset_mode_q & ~load_n) & buf_out_valid;

    assign p.wr_inc  = data_wr;
    assign p.rd_inc  = data_rd;

    // Strap captured on every reset clock, held afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            offset_mode_q <= ~load_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array and prefetch into the read buffer
    always_ff @(posedge clk_i) begin
        if (data_wr) begin
            mem_q[p.wr_ptr[dcf_pkg::ADDR_W-1:0]] <= wr_data_i;
        end
    end

    assign buf_in_valid = (fetch_q != p.wr_sync);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_q <= '0;
        end else if (buf_in_valid & buf_in_ready) begin
            fetch_q <= fetch_q + 9'h001;
        end
    end

    dcf_buf u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (mem_q[fetch_q[dcf_pkg::ADDR_W-1:0]]),
        .out_valid_o (buf_out_valid),
        .out_ready_i (data_rd),
        .out_data_o  (buf_out_data)
    );

    dcf_flags u_flags (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .p     (p.flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_q <= '0;
        end else if (load_rd) begin
            rd_data_q <= off_byte(seq_q, eoff_q, foff_q);
        end else if (data_rd) begin
            rd_data_q <= buf_out_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset registers, pin sequence first, Wishbone second
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    assign wb_wr  = wb_req & wb_we_i & offset_mode_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_q <= dcf_pkg::DCF_SEQ_ELSB;
        end else if (load_wr | load_rd) begin
            case (seq_q)
                dcf_pkg::DCF_SEQ_ELSB: seq_q <= dcf_pkg::DCF_SEQ_EMSB;
                dcf_pkg::DCF_SEQ_EMSB: seq_q <= dcf_pkg::DCF_SEQ_FLSB;
                dcf_pkg::DCF_SEQ_FLSB: seq_q <= dcf_pkg::DCF_SEQ_FMSB;
                default:               seq_q <= dcf_pkg::DCF_SEQ_ELSB;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eoff_q <= dcf_pkg::OFF_DEFAULT;
            foff_q <= dcf_pkg::OFF_DEFAULT;
        end else if (load_wr) begin
            case (seq_q)
                dcf_pkg::DCF_SEQ_ELSB: eoff_q[7:0]  <= wr_data_i[7:0];
                dcf_pkg::DCF_SEQ_EMSB: eoff_q[11:8] <= wr_data_i[3:0];
                dcf_pkg::DCF_SEQ_FLSB: foff_q[7:0]  <= wr_data_i[7:0];
                default:               foff_q[11:8] <= wr_data_i[3:0];
            endcase
        end else if (wb_wr && wb_adr_i == dcf_pkg::ADR_EOFF) begin
            if (wb_sel_i[0]) begin
                eoff_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                eoff_q[11:8] <= wb_dat_i[11:8];
            end
        end else if (wb_wr && wb_adr_i == dcf_pkg::ADR_FOFF) begin
            if (wb_sel_i[0]) begin
                foff_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                foff_q[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    assign p.empty_off = eoff_q;
    assign p.full_off  = foff_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle ack, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
        end else begin
            wb_ack_q <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_q <= '0;
        end else if (wb_req) begin
            case (wb_adr_i)
                dcf_pkg::ADR_STATUS: begin
                    wb_dat_q                       <= '0;
                    wb_dat_q[dcf_pkg::ST_EMPTY_N]  <= p.empty_n;
                    wb_dat_q[dcf_pkg::ST_AEMPTY_N] <= p.aempty_n;
                    wb_dat_q[dcf_pkg::ST_AFULL_N]  <= p.afull_n;
                    wb_dat_q[dcf_pkg::ST_FULL_N]   <= p.full_n;
                    wb_dat_q[dcf_pkg::ST_OFFMODE]  <= offset_mode_q;
                    wb_dat_q[dcf_pkg::ST_COUNT +: dcf_pkg::PTR_W] <= p.count;
                end
                dcf_pkg::ADR_EOFF: wb_dat_q <= {20'h00000, eoff_q};
                dcf_pkg::ADR_FOFF: wb_dat_q <= {20'h00000, foff_q};
                default:           wb_dat_q <= '0;
            endcase
        end
    end

    assign rd_data_o             = rd_data_q;
    assign empty_flag_n_o        = p.empty_n;
    assign full_flag_n_o         = p.full_n;
    assign almost_empty_flag_n_o = p.aempty_n;
    assign almost_full_flag_n_o  = p.afull_n;
    assign wb_dat_o              = wb_dat_q;
    assign wb_ack_o              = wb_ack_q;
endmodule : dcf_top

// ---- dcf_top_checker.sv ----
// Port-level assertions for the flagged FIFO channel
module dcf_top_checker (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic                        write_enable_n_i,
    input wire logic                        write_enable_second_or_load_n_i,
    input wire logic                        read_enable_n_i,
    input wire logic                        read_enable_second_n_i,
    input wire logic [dcf_pkg::DATA_W-1:0]  rd_data_o,
    input wire logic                        empty_flag_n_o,
    input wire logic                        full_flag_n_o,
    input wire logic                        almost_empty_flag_n_o,
    input wire logic                        almost_full_flag_n_o,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic                        wb_ack_o
);
    logic offset_mode_q;
    logic ld_n;
    logic wr_take;
    logic rd_en;
    logic rd_take;
    logic any_rd;
    ////////////////////////////////////////////////////////////////
    // Strap copy taken while reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            offset_mode_q <= !write_enable_second_or_load_n_i;
        end
    end
    assign ld_n = write_enable_second_or_load_n_i;
    assign wr_take = !write_enable_n_i && full_flag_n_o && (ld_n == offset_mode_q);
    assign rd_en = !read_enable_n_i && !read_enable_second_n_i;
    assign rd_take = rd_en && empty_flag_n_o && !(offset_mode_q && !ld_n);
    assign any_rd = rd_en && (empty_flag_n_o || (offset_mode_q && !ld_n));
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence word_arrives;
        ##[1:4] empty_flag_n_o;
    endsequence
    ack_follow_a: assert property (wb_req |=> wb_ack_o)
        else $error("bus request not acknowledged");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    reset_flags_a: assert property ($fell(rst_i) |-> !empty_flag_n_o && full_flag_n_o
        && almost_full_flag_n_o && !almost_empty_flag_n_o)
        else $error("flags wrong after reset");
    first_word_a: assert property (wr_take && !empty_flag_n_o |-> word_arrives)
        else $error("first word late");
    empty_rise_a: assert property ($rose(empty_flag_n_o) |->
        $past(wr_take, 2) || $past(wr_take, 3) || $past(wr_take, 4))
        else $error("empty flag cleared without write");
    empty_by_read_a: assert property ($fell(empty_flag_n_o) |-> $past(rd_take))
        else $error("empty flag set without read");
    full_by_write_a: assert property ($fell(full_flag_n_o) |-> $past(wr_take))
        else $error("full flag set without write");
    full_afull_a: assert property (!full_flag_n_o |-> !almost_full_flag_n_o)
        else $error("full without almost full");
    empty_aempty_a: assert property (!empty_flag_n_o |-> !almost_empty_flag_n_o)
        else $error("empty without almost empty");
    hold_data_a: assert property (!any_rd |=> $stable(rd_data_o))
        else $error("read data moved without read");
endmodule : dcf_top_checker

bind dcf_top dcf_top_checker u_checker (
    .clk_i(clk_i), .rst_i(rst_i), .write_enable_n_i(write_enable_n_i),
    .write_enable_second_or_load_n_i(write_enable_second_or_load_n_i),
    .read_enable_n_i(read_enable_n_i), .read_enable_second_n_i(read_enable_second_n_i),
    .rd_data_o(rd_data_o), .empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o),
    .almost_empty_flag_n_o(almost_empty_flag_n_o),
    .almost_full_flag_n_o(almost_full_flag_n_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

// ---- dcf_peer.sv ----
// Writer and reader logic facing the channel pins
module dcf_peer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [9:0]  wr_limit_i,
    input  wire logic [9:0]  rd_limit_i,
    input  wire logic        rd_run_i,
    input  wire logic        load_n_i,
    input  wire logic        full_flag_n_i,
    input  wire logic        empty_flag_n_i,
    input  wire logic [8:0]  rd_data_i,
    output logic [8:0]       wr_data_o,
    output logic             write_enable_n_o,
    output logic             read_enable_n_o,
    output logic             read_enable_second_n_o,
    output logic [9:0]       wr_count_o,
    output logic [9:0]       rd_count_o,
    output logic [7:0]       bad_count_o
);
    logic       rd_take;
    logic       pend_q;
    logic [8:0] exp_q;
    assign wr_data_o = wr_count_o[8:0];
    assign write_enable_n_o = !(wr_count_o < wr_limit_i);
    assign rd_take = rd_run_i && load_n_i && empty_flag_n_i && (rd_count_o < rd_limit_i);
    assign read_enable_n_o = !(rd_take || (rd_run_i && !load_n_i));
    assign read_enable_second_n_o = 1'b0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_count_o <= 10'h000;
            rd_count_o <= 10'h000;
            bad_count_o <= 8'h00;
            pend_q <= 1'b0;
            exp_q <= 9'h000;
        end else begin
            if (!write_enable_n_o && full_flag_n_i) begin
                wr_count_o <= wr_count_o + 10'h001;
            end
            if (rd_take) begin
                rd_count_o <= rd_count_o + 10'h001;
            end
            pend_q <= rd_take;
            exp_q <= rd_count_o[8:0];
            if (pend_q && rd_data_i !== exp_q) begin
                bad_count_o <= bad_count_o + 8'h01;
            end
        end
    end
endmodule : dcf_peer

// ---- dcf_top_tb.sv ----
// Self-checking bench for the flagged FIFO channel
module dcf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, ld_n = 1'b0, t_we_n = 1'b1, rd_run = 1'b0;
    logic [8:0] t_dat = 9'h000, p_dat, wdata, rd_data;
    logic [9:0] wl = 10'h000, rl = 10'h000, wcnt, rcnt;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, p_we_n, ren_n, ren2_n;
    logic empty_n, full_n, aempty_n, afull_n;
    logic [7:0] adr = 8'h00, bad;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, tmp;
    int err_count = 0, tests_run = 0, n;
    assign wdata = t_we_n ? p_dat : t_dat;
    dcf_top dut (.clk_i(clk_i), .rst_i(rst_i), .wr_data_i(wdata),
        .write_enable_n_i(p_we_n & t_we_n), .write_enable_second_or_load_n_i(ld_n),
        .read_enable_n_i(ren_n), .read_enable_second_n_i(ren2_n), .rd_data_o(rd_data),
        .empty_flag_n_o(empty_n), .full_flag_n_o(full_n), .almost_empty_flag_n_o(aempty_n),
        .almost_full_flag_n_o(afull_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    dcf_peer peer (.clk_i(clk_i), .rst_i(rst_i), .wr_limit_i(wl), .rd_limit_i(rl),
        .rd_run_i(rd_run), .load_n_i(ld_n), .full_flag_n_i(full_n), .empty_flag_n_i(empty_n),
        .rd_data_i(rd_data), .wr_data_o(p_dat), .write_enable_n_o(p_we_n),
        .read_enable_n_o(ren_n), .read_enable_second_n_o(ren2_n), .wr_count_o(wcnt),
        .rd_count_o(rcnt), .bad_count_o(bad));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] act, input logic [31:0] exp);
        tests_run++;
        if (act !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk
    task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                  input logic [3:0] s, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb_cycle
    task wb_check(input logic [7:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0, 4'hf, tmp);
        chk(tmp, exp);
    endtask : wb_check
    task step(input logic [9:0] w, input logic [9:0] r);
        @(posedge clk_i);
        wl <= w;
        rl <= r;
        repeat (300) @(posedge clk_i);
        #1;
    endtask : step
    task do_reset(input logic strap);
        @(posedge clk_i);
        rst_i <= 1'b1;
        ld_n <= strap;
        wl <= 10'h000;
        rl <= 10'h000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        ld_n <= 1'b1;
    endtask : do_reset
    task print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
    initial begin
        do_reset(1'b0);
        wb_check(dcf_pkg::ADR_STATUS, 32'h0000001c);
        wb_check(dcf_pkg::ADR_EOFF, 32'h00000007);
        wb_check(dcf_pkg::ADR_FOFF, 32'h00000007);
        wb_check(8'h0c, 32'h00000000);
        $display("test reset values done");
        @(posedge clk_i);
        wl <= 10'h001;
        rd_run <= 1'b1;
        @(posedge clk_i);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (empty_n !== 1'b1 && n < 10);
        chk(n, 2);
        step(10'd1, 10'd1);
        chk(empty_n, 1'b0);
        $display("test first word done");
        rd_run <= 1'b0;
        step(10'd249, 10'd1);
        chk(afull_n, 1'b1);
        step(10'd250, 10'd1);
        chk(afull_n, 1'b0);
        step(10'd256, 10'd1);
        chk(full_n, 1'b1);
        step(10'd260, 10'd1);
        chk(full_n, 1'b0);
        chk(wcnt, 10'd257);
        $display("test fill done");
        rd_run <= 1'b1;
        step(10'd257, 10'd249);
        chk(aempty_n, 1'b1);
        step(10'd257, 10'd250);
        chk(aempty_n, 1'b0);
        step(10'd257, 10'd260);
        chk(empty_n, 1'b0);
        chk(rcnt, 10'd257);
        chk(bad, 8'h00);
        $display("test drain done");
        rd_run <= 1'b0;
        ld_n <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            t_we_n <= 1'b0;
            t_dat <= (i == 0) ? 9'h003 : ((i == 2) ? 9'h005 : 9'h000);
        end
        @(posedge clk_i);
        t_we_n <= 1'b1;
        rd_run <= 1'b1;
        @(posedge clk_i);
        rd_run <= 1'b0;
        ld_n <= 1'b1;
        #1;
        chk(rd_data, 9'h003);
        wb_check(dcf_pkg::ADR_EOFF, 32'h00000003);
        wb_check(dcf_pkg::ADR_FOFF, 32'h00000005);
        wb_cycle(1'b1, dcf_pkg::ADR_FOFF, 32'h00000abc, 4'h1, tmp);
        wb_check(dcf_pkg::ADR_FOFF, 32'h000000bc);
        $display("test offset load done");
        do_reset(1'b1);
        wb_check(dcf_pkg::ADR_STATUS, 32'h0000000c);
        wb_cycle(1'b1, dcf_pkg::ADR_EOFF, 32'h00000005, 4'h3, tmp);
        wb_check(dcf_pkg::ADR_EOFF, 32'h00000007);
        step(10'd1, 10'd0);
        chk(empty_n, 1'b0);
        ld_n <= 1'b0;
        step(10'd2, 10'd0);
        chk(empty_n, 1'b1);
        $display("test depth mode done");
        print_verdict();
    end
endmodule : dcf_top_tb
